// File: rtl/flash_ctrl_pkg.sv
// Constants and types shared by the flash program and erase controller.
//==============================================================================
// Operation
// RULE1 - Flash is programmed one byte per operation, from debug port or data writes.
// RULE2 - A byte write only clears bits; only page erase sets them to one.
// RULE3 - Writes and erases are timed internally; no polling is needed.
// RULE4 - The core is stalled for the whole write or erase.
// RULE5 - Keys 0xA5 then 0xF1, any spacing, arm one flash operation.
// RULE6 - A wrong or out-of-order key locks flash writes until reset.
// RULE7 - A flash attempt before both keys locks flash writes until reset.
// RULE8 - After each write or erase the key mechanism relocks.
// RULE9 - Write-enable bit 0 of control steers data writes to flash.
// RULE10 - Hardware never clears the write-enable bit.
// RULE11 - Pages are 512 bytes; erase sets every byte of the page to 0xFF.
// RULE12 - Erase and write enabled plus keys: a data write erases its page.
// RULE13 - Write enabled, erase clear, keys: a data write programs one byte.
// RULE14 - Software repeats keys and one write for every byte.
// RULE15 - Data reads go to data RAM; code reads return flash contents.
// RULE16 - Software should disable interrupts before flash sequences.
// RULE17 - Software should erase a page before programming its bytes.
// RULE18 - Software should clear the enables after flash work ends.
// RULE19 - A blank part is programmable only through the debug port.
// RULE20 - No software write without write-enable; no erase without both enables.
// RULE21 - With write-enable clear, data writes go to RAM and leave keys alone.
package flash_ctrl_pkg;
  localparam logic [7:0] KEY_FIRST     = 8'hA5;
  localparam logic [7:0] KEY_SECOND    = 8'hF1;
  localparam logic [7:0] ERASED_BYTE   = 8'hFF;
  localparam int         CTL_WE_BIT    = 0;
  localparam int         CTL_EE_BIT    = 1;
  localparam int         PAGE_BYTES    = 512;
  localparam int         CLOCK_MHZ     = 20;
  localparam int         WRITE_TIME_NS = 1000;
  localparam int         ERASE_TIME_NS = 20000;
  localparam int         WRITE_CYCLES  = (WRITE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int         ERASE_CYCLES  = (ERASE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_ARMED, KEY_DEAD} key_state_t;
  typedef enum logic [1:0] {OP_IDLE, OP_WRITE, OP_ERASE} op_state_t;
endpackage

// File: rtl/op_timer.sv
// Down-counter that times one flash write or erase.
`timescale 1ns/10ps
module op_timer
  import flash_ctrl_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input  wire logic             clock,
  input  wire logic             rst,
  // Control.
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] length,
  // Status.
  output logic                  busy,
  output logic                  done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             busy;
    logic             done;
  } timer_t;
  timer_t state;
  timer_t next_state;

  always_comb begin
    next_state      = state;
    next_state.done = 1'b0;
    if (start) begin
      next_state.count = length;
      next_state.busy  = 1'b1;
    end else if (state.busy) begin
      if (state.count <= WIDTH'(1)) begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end else begin
        next_state.count = state.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
  assign done = state.done;
endmodule // op_timer

// File: rtl/flash_program_erase_control.sv
// Flash lock-and-key sequencer with self-timed byte write and page erase.
`timescale 1ns/10ps
module flash_program_erase_control
  import flash_ctrl_pkg::*;
#(
  parameter int ADDR_W        = 14,
  parameter int FLASH_BYTES   = 16384,
  parameter int WRITE_LEN     = WRITE_CYCLES,
  parameter int ERASE_LEN     = ERASE_CYCLES
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst,
  // Program store control register write.
  input  wire logic              ctl_wr,
  input  wire logic [7:0]        ctl_wdata,
  // Key register write.
  input  wire logic              key_wr,
  input  wire logic [7:0]        key_wdata,
  // Data-move write and read cycles from the core.
  input  wire logic              xwr,
  input  wire logic              xrd,
  input  wire logic [ADDR_W-1:0] xaddr,
  input  wire logic [7:0]        xwdata,
  // Code-move read.
  input  wire logic              crd,
  input  wire logic [ADDR_W-1:0] caddr,
  // Debug port programming.
  input  wire logic              dbg_wr,
  input  wire logic              dbg_erase,
  input  wire logic [ADDR_W-1:0] dbg_addr,
  input  wire logic [7:0]        dbg_wdata,
  // Data RAM write and read request outputs.
  output logic                   ram_wr,
  output logic                   ram_rd,
  output logic [ADDR_W-1:0]      ram_addr,
  output logic [7:0]             ram_wdata,
  // Code read data and status.
  output logic [7:0]             code_rdata,
  output logic                   code_valid,
  output logic                   core_stall,
  output logic                   write_enable,
  output logic                   erase_enable,
  output logic                   flash_locked_out,
  output logic                   key_armed
);
  localparam int PAGE_W = $clog2(PAGE_BYTES);
  localparam int TW     = $clog2(ERASE_LEN + 1) + 1;

  typedef struct packed {
    key_state_t          key;
    op_state_t           op;
    logic                we;
    logic                ee;
    logic [ADDR_W-1:0]   op_addr;
    logic [7:0]          op_data;
    logic                stall;
    logic                dead;
    logic                armed;
    logic                ram_wr;
    logic                ram_rd;
    logic [ADDR_W-1:0]   ram_addr;
    logic [7:0]          ram_wdata;
    logic [7:0]          code_rdata;
    logic                code_valid;
  } ctl_state_t;
  ctl_state_t state;
  ctl_state_t next_state;

  logic [7:0]    flash_mem [FLASH_BYTES];
  logic          timer_busy;
  logic          timer_done;
  logic          timer_start;
  logic [TW-1:0] timer_len;
  logic          sw_flash;
  logic          mem_write;
  logic          page_erase;
  logic [7:0]    mem_data;

  op_timer #(.WIDTH(TW)) u_timer (
    .clock  (clock),
    .rst    (rst),
    .start  (timer_start),
    .length (timer_len),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  //============================================================================
  // Sequencer.
  //============================================================================
  // Data-move writes reach flash only while write-enable is set.
  assign sw_flash = xwr && state.we && (state.op == OP_IDLE); // RULE9 RULE20 RULE21

  always_comb begin
    next_state            = state;
    next_state.ram_wr     = 1'b0;
    next_state.ram_rd     = 1'b0;
    next_state.code_valid = 1'b0;
    timer_start           = 1'b0;
    timer_len             = '0;
    // Control register: hardware never clears write-enable.
    if (ctl_wr) begin // RULE10
      next_state.we = ctl_wdata[CTL_WE_BIT];
      next_state.ee = ctl_wdata[CTL_EE_BIT];
    end
    // Key sequence; any error is sticky until reset.
    if (key_wr && state.key != KEY_DEAD) begin // RULE5 RULE6
      case (state.key)
        KEY_LOCKED: next_state.key = (key_wdata == KEY_FIRST) ? KEY_HALF : KEY_DEAD;
        KEY_HALF:   next_state.key = (key_wdata == KEY_SECOND) ? KEY_ARMED : KEY_DEAD;
        default:    next_state.key = KEY_DEAD;
      endcase
    end
    // Ordinary data RAM traffic; reads always go to RAM.
    if (xrd) begin // RULE15
      next_state.ram_rd   = 1'b1;
      next_state.ram_addr = xaddr;
    end
    if (xwr && !state.we) begin // RULE21
      next_state.ram_wr    = 1'b1;
      next_state.ram_addr  = xaddr;
      next_state.ram_wdata = xwdata;
    end
    case (state.op)
      OP_IDLE: begin
        if (sw_flash) begin
          if (state.key == KEY_ARMED) begin // RULE12 RULE13
            next_state.op_addr   = xaddr;
            next_state.op_data   = xwdata;
            next_state.op        = state.ee ? OP_ERASE : OP_WRITE;
            timer_start          = 1'b1;
            timer_len            = state.ee ? TW'(ERASE_LEN) : TW'(WRITE_LEN); // RULE3
          end else begin
            next_state.key = KEY_DEAD; // RULE7
          end
        end else if (dbg_wr || dbg_erase) begin // RULE1 RULE19
          next_state.op_addr   = dbg_addr;
          next_state.op_data   = dbg_wdata;
          next_state.op        = dbg_erase ? OP_ERASE : OP_WRITE;
          timer_start          = 1'b1;
          timer_len            = dbg_erase ? TW'(ERASE_LEN) : TW'(WRITE_LEN);
        end
      end
      OP_WRITE, OP_ERASE: begin
        if (timer_done) begin
          next_state.op = OP_IDLE;
          if (state.key == KEY_ARMED) begin
            next_state.key = KEY_LOCKED; // RULE8
          end
        end
      end
      default: next_state.op = OP_IDLE;
    endcase
    // Code reads return flash contents.
    if (crd) begin // RULE15
      next_state.code_rdata = flash_mem[caddr];
      next_state.code_valid = 1'b1;
    end
    // Status outputs are registered copies of the next state.
    next_state.stall = (next_state.op != OP_IDLE); // RULE4
    next_state.dead  = (next_state.key == KEY_DEAD);
    next_state.armed = (next_state.key == KEY_ARMED);
  end

  //============================================================================
  // Flash array update.
  //============================================================================
  // A byte write lands when its timer expires; an erase sets its whole page to 0xFF in one cycle when its timer expires.
  always_comb begin
    mem_write  = 1'b0;
    page_erase = 1'b0;
    mem_data   = flash_mem[state.op_addr] & state.op_data; // RULE2
    if (timer_done) begin
      mem_write  = (state.op == OP_WRITE);
      page_erase = (state.op == OP_ERASE);
    end
  end

  always_ff @(posedge clock) begin
    if (page_erase) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        flash_mem[{state.op_addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= ERASED_BYTE; // RULE11
      end
    end else if (mem_write) begin
      flash_mem[state.op_addr] <= mem_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign ram_wr           = state.ram_wr;
  assign ram_rd           = state.ram_rd;
  assign ram_addr         = state.ram_addr;
  assign ram_wdata        = state.ram_wdata;
  assign code_rdata       = state.code_rdata;
  assign code_valid       = state.code_valid;
  assign core_stall       = state.stall; // RULE4
  assign write_enable     = state.we;
  assign erase_enable     = state.ee;
  assign flash_locked_out = state.dead;
  assign key_armed        = state.armed;

  //============================================================================
  // Assertions.
  //============================================================================
  property p_stall_busy;
    @(posedge clock) disable iff (rst) (state.op != OP_IDLE) |-> core_stall;
  endproperty
  a_stall_busy: assert property (p_stall_busy) else $error("stall missing"); // RULE4

  property p_dead_sticky;
    @(posedge clock) disable iff (rst) flash_locked_out |=> flash_locked_out;
  endproperty
  a_dead_sticky: assert property (p_dead_sticky) else $error("lockout left"); // RULE6

  property p_bad_key;
    @(posedge clock) disable iff (rst)
      (key_wr && state.key == KEY_LOCKED && key_wdata != KEY_FIRST) |=> flash_locked_out;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("bad key accepted"); // RULE6

  property p_arm;
    @(posedge clock) disable iff (rst)
      (key_wr && state.key == KEY_HALF && key_wdata == KEY_SECOND) |=> key_armed;
  endproperty
  a_arm: assert property (p_arm) else $error("keys did not arm"); // RULE5

  property p_early;
    @(posedge clock) disable iff (rst)
      (sw_flash && state.key != KEY_ARMED) |=> flash_locked_out;
  endproperty
  a_early: assert property (p_early) else $error("early attempt not locked"); // RULE7

  property p_relock;
    @(posedge clock) disable iff (rst)
      (state.op != OP_IDLE && timer_done && key_armed) |=> !key_armed;
  endproperty
  a_relock: assert property (p_relock) else $error("key not relocked"); // RULE8

  property p_we_hold;
    @(posedge clock) disable iff (rst) (write_enable && !ctl_wr) |=> write_enable;
  endproperty
  a_we_hold: assert property (p_we_hold) else $error("write enable dropped"); // RULE10

  property p_ram_write;
    @(posedge clock) disable iff (rst) (xwr && !write_enable) |=> ram_wr;
  endproperty
  a_ram_write: assert property (p_ram_write) else $error("ram write lost"); // RULE21

  property p_write_time;
    @(posedge clock) disable iff (rst)
      (state.op == OP_IDLE ##1 state.op == OP_WRITE) |-> core_stall [*2];
  endproperty
  a_write_time: assert property (p_write_time) else $error("write too short"); // RULE3

  property p_timer_stall;
    @(posedge clock) disable iff (rst) timer_busy |-> core_stall;
  endproperty
  a_timer_stall: assert property (p_timer_stall) else $error("timer ran without stall"); // RULE3

  c_erase: cover property (@(posedge clock) state.op == OP_ERASE);
  c_write: cover property (@(posedge clock) state.op == OP_WRITE);
  c_dead:  cover property (@(posedge clock) flash_locked_out);
endmodule // flash_program_erase_control

// File: testbench/core_model.sv
// Processor core stand-in that issues control, key, data, code and debug cycles.
`timescale 1ns/10ps
module core_model
  import flash_ctrl_pkg::*;
#(
  parameter int AW = 14
) (
  // Clock, then inputs from the sequencer.
  input  wire logic          clock,
  input  wire logic          core_stall,
  input  wire logic          code_valid,
  input  wire logic [7:0]    code_rdata,
  // Request strobes and operands.
  output logic               ctl_wr,
  output logic [7:0]         ctl_wdata,
  output logic               key_wr,
  output logic [7:0]         key_wdata,
  output logic               xwr,
  output logic               xrd,
  output logic [AW-1:0]      xaddr,
  output logic [7:0]         xwdata,
  output logic               crd,
  output logic [AW-1:0]      caddr,
  output logic               dbg_wr,
  output logic               dbg_erase,
  output logic [AW-1:0]      dbg_addr,
  output logic [7:0]         dbg_wdata
);
  initial begin
    {ctl_wr, key_wr, xwr, xrd, crd, dbg_wr, dbg_erase} = 7'h00;
    {ctl_wdata, key_wdata, xwdata, dbg_wdata} = 32'h0;
    {xaddr, caddr, dbg_addr} = '0;
  end

  // One cycle: idle gap, wait out a stall, strobe for one edge, then scramble operands.
  task automatic cyc(input int kind, input logic [AW-1:0] a, input logic [7:0] d,
                     input int gap, output logic v, output logic [7:0] q);
    repeat (gap) @(posedge clock);
    @(negedge clock);
    while (core_stall === 1'b1) @(negedge clock);
    @(posedge clock);
    {ctl_wr, key_wr, xwr, xrd, crd, dbg_wr, dbg_erase} <= 7'h40 >> kind;
    {xaddr, caddr, dbg_addr} <= {a, a, a};
    {ctl_wdata, key_wdata, xwdata, dbg_wdata} <= {d, d, d, d};
    @(posedge clock);
    {ctl_wr, key_wr, xwr, xrd, crd, dbg_wr, dbg_erase} <= 7'h00;
    {xaddr, caddr, dbg_addr} <= ~{a, a, a};
    {ctl_wdata, key_wdata, xwdata, dbg_wdata} <= ~{d, d, d, d};
    @(negedge clock);
    // Let the bench's falling-edge monitors settle before the caller looks.
    #1;
    v = code_valid;
    q = code_rdata;
  endtask

  // Ordered key pair ahead of each single flash operation.
  task automatic key_pair(input int gap);
    logic       v;
    logic [7:0] q;
    cyc(1, '0, KEY_FIRST, 0, v, q);
    cyc(1, '0, KEY_SECOND, gap, v, q);
  endtask
endmodule // core_model

// File: testbench/flash_program_erase_control_tb.sv
// Self-checking bench for the flash program and erase sequencer.
`timescale 1ns/10ps
module flash_program_erase_control_tb;
  import flash_ctrl_pkg::*;
  localparam int WL = 3;
  localparam int EL = 8;
  localparam int CTL = 0, KEY = 1, XW = 2, XR = 3, CR = 4, DW = 5, DE = 6;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        ctl_wr, key_wr, xwr, xrd, crd, dbg_wr, dbg_erase;
  logic [7:0]  ctl_wdata, key_wdata, xwdata, dbg_wdata, code_rdata, ram_wdata, wd;
  logic [13:0] xaddr, caddr, dbg_addr, ram_addr, wa;
  logic        ram_wr, ram_rd, code_valid, core_stall;
  logic        write_enable, erase_enable, flash_locked_out, key_armed, v;
  logic [7:0]  q;
  int          miscompares = 0, n_tests = 0, wr_n = 0, rd_n = 0, n;
  logic [7:0]  bad1 [2] = '{8'hF1, 8'hA5};
  logic [7:0]  bad2 [2] = '{8'hA5, 8'h12};

  always #25 clock = ~clock;

  flash_program_erase_control #(.WRITE_LEN(WL), .ERASE_LEN(EL)) dut_u (
    .clock(clock), .rst(rst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .key_wr(key_wr),
    .key_wdata(key_wdata), .xwr(xwr), .xrd(xrd), .xaddr(xaddr), .xwdata(xwdata), .crd(crd),
    .caddr(caddr), .dbg_wr(dbg_wr), .dbg_erase(dbg_erase), .dbg_addr(dbg_addr),
    .dbg_wdata(dbg_wdata), .ram_wr(ram_wr), .ram_rd(ram_rd), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .code_rdata(code_rdata), .code_valid(code_valid),
    .core_stall(core_stall), .write_enable(write_enable), .erase_enable(erase_enable),
    .flash_locked_out(flash_locked_out), .key_armed(key_armed));

  core_model core_u (
    .clock(clock), .core_stall(core_stall), .code_valid(code_valid),
    .code_rdata(code_rdata), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .key_wr(key_wr),
    .key_wdata(key_wdata), .xwr(xwr), .xrd(xrd), .xaddr(xaddr), .xwdata(xwdata),
    .crd(crd), .caddr(caddr), .dbg_wr(dbg_wr), .dbg_erase(dbg_erase),
    .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata));

  // Data RAM traffic seen at the outputs.
  always @(negedge clock) begin
    if (ram_wr === 1'b1) begin
      wr_n++;
      wa = ram_addr;
      wd = ram_wdata;
    end
    if (ram_rd === 1'b1) rd_n++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int exp, input string m);
    n_tests++;
    if (got != exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %0d expected %0d", $time, m, got, exp);
    end
  endtask

  task automatic op(input int kind, input logic [13:0] a, input logic [7:0] d, input int gap);
    core_u.cyc(kind, a, d, gap, v, q);
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] exp);
    core_u.cyc(CR, a, 8'h00, 0, v, q);
    chk({7'h00, v}, 8'h01, "code read valid");
    chk(q, exp, "code read data");
  endtask

  // Counts stall cycles starting in the cycle after the accepted write.
  task automatic stall_len(input int exp, input string m);
    n = 0;
    while (core_stall === 1'b1 && n < 50) begin
      n++;
      @(negedge clock);
    end
    chk_n(n, exp, m);
  endtask

  task automatic reset_dut();
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    reset_dut();
    @(negedge clock);
    chk({3'h0, write_enable, erase_enable, key_armed, flash_locked_out, core_stall}, 8'h00,
        "status after reset");
    op(DE, 14'h0000, 8'h00, 0);
    op(DW, 14'h0005, 8'h3C, EL + 4);
    op(CR, 14'h0005, 8'h00, EL + 4);
    chk(q, 8'h3C, "debug byte");
    rd(14'h01FF, ERASED_BYTE);
    op(KEY, 14'h0, KEY_FIRST, 0);
    op(XW, 14'h0123, 8'h5A, 0);
    chk_n(wr_n, 1, "ram write count");
    chk(wd, 8'h5A, "ram write data");
    chk(wa[7:0], 8'h23, "ram write address low");
    chk({2'h0, wa[13:8]}, 8'h01, "ram write address high");
    op(KEY, 14'h0, KEY_SECOND, 3);
    chk({7'h00, key_armed}, 8'h01, "armed across ram write");
    op(CTL, 14'h0, 8'h02, 0);
    op(XW, 14'h0240, 8'h00, 0);
    stall_len(0, "erase enable alone");
    chk_n(wr_n, 2, "ram write with erase only");
    op(CTL, 14'h0, 8'h03, 0);
    op(XW, 14'h0277, 8'h12, 0);
    stall_len(EL + 1, "erase stall");
    chk({6'h00, key_armed, write_enable}, 8'h01, "relock, enable kept");
    rd(14'h0200, ERASED_BYTE);
    rd(14'h03FF, ERASED_BYTE);
    rd(14'h0005, 8'h3C);
    op(CTL, 14'h0, 8'h01, 0);
    core_u.key_pair(6);
    op(XW, 14'h0210, 8'hA6, 0);
    stall_len(WL + 1, "write stall");
    rd(14'h0210, 8'hA6);
    rd(14'h0211, ERASED_BYTE);
    chk_n(wr_n, 2, "flash write reached ram");
    core_u.key_pair(0);
    op(XW, 14'h0210, 8'h5F, 0);
    stall_len(WL + 1, "second write stall");
    rd(14'h0210, 8'h06);
    op(XR, 14'h0210, 8'h00, 0);
    chk_n(rd_n, 1, "data read to ram");
    op(CTL, 14'h0, 8'h00, 0);
    chk({6'h00, write_enable, erase_enable}, 8'h00, "enables cleared");
    for (int i = 0; i < 3; i++) begin
      reset_dut();
      op(CTL, 14'h0, 8'h01, 0);
      if (i < 2) begin
        op(KEY, 14'h0, bad1[i], 0);
        op(KEY, 14'h0, bad2[i], 0);
      end else begin
        op(XW, 14'h0300, 8'h00, 0);
      end
      chk({7'h00, flash_locked_out}, 8'h01, "lockout flag");
      core_u.key_pair(0);
      op(XW, 14'h0301, 8'h00, 0);
      stall_len(0, "locked write stall");
      rd(14'h0301, ERASED_BYTE);
    end
    conclude();
  end
endmodule // flash_program_erase_control_tb
